/* File: tisp_unit.sv */
// Top of the timer, vectored interrupt and current-sink port unit with its AXI4-Lite slave.
// Operation
// RULE1: Eight interrupt sources, each individually maskable by software.
// RULE2: Sources: bus reset, timer 128 us, timer 1.024 ms, three endpoints, sink, GPIO.
// RULE3: Timer interrupts fire on the timer bit rising only.
// RULE4: Endpoint interrupt after each packet moved on that endpoint, either direction.
// RULE5: Any GPIO pin may interrupt; all share one vector.
// RULE6: Sink port pins share their own separate vector.
// RULE7: Per-pin enable picks which sink inputs may interrupt.
// RULE8: Per-input mask picks which GPIO inputs may interrupt.
// RULE9: Each sink pin has its own trigger direction.
// RULE10: Each GPIO port has one trigger direction for the whole port.
// RULE11: A trigger direction is either rising or falling edge.
// RULE12: Free running 12-bit timer counts once per microsecond, always readable.
// RULE13: Reading the timer low byte copies the upper nibble to a holding register.
// RULE14: Reading the upper nibble returns the holding register, not the live count.
// RULE15: Writing one to a sink pin stops its sink and enables its pull-up.
// RULE16: Writing zero to a sink pin drops the pull-up and sinks the programmed level.
// RULE17: Each of eight sink pins has a sixteen-step sink level.
// RULE18: Software writes one to a sink pin before using it as input.
// RULE19: Requests stay pending until acknowledged or cleared; masked ones never reach the core.
//
// Chosen here: the AXI4-Lite slave port and the address map.
module tisp_unit
  import tisp_pkg::*;
#(
  parameter int GPIO_PORTS = 4,
  parameter int DIV        = TICK_DIV
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic [AXI_ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          usb_bus_reset_evt,
  input  wire logic [N_EP-1:0]               usb_ep_done,
  input  wire logic                          irq_ack,
  input  wire logic [2:0]                    irq_ack_vector,
  output logic                               irq,
  output tisp_vec_t                          irq_vector,
  input  wire logic [SINK_N-1:0]             sink_pin_in,
  output tisp_sink_drive_t                   sink_drive,
  input  wire logic [GPIO_PORTS*8-1:0]       gpio_pin_in
);

  localparam int GW = GPIO_PORTS * GPIO_PORT_W;

  if (GPIO_PORTS < 1 || GPIO_PORTS > 4) begin : g_chk
    $error("tisp_unit: GPIO_PORTS must be 1 to 4");
  end

  // ========
  // State
  logic                  awready_reg;
  logic                  wready_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [1:0]            rresp_reg;
  logic [31:0]           rdata_reg;
  logic                  aw_have_reg;
  logic                  w_have_reg;
  logic                  ar_have_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic [AXI_ADDR_W-1:0] ar_addr_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;

  logic [N_SRC-1:0]      status_reg;
  logic [N_SRC-1:0]      mask_reg;
  logic                  irq_reg;
  tisp_vec_t             vec_reg;
  logic [SINK_N-1:0]     sink_ien_reg;
  logic [SINK_N-1:0]     sink_pol_reg;
  tisp_sink_drive_t      drive_reg;
  logic [GW-1:0]         gpio_mask_reg;
  logic [GPIO_PORTS-1:0] gpio_pol_reg;

  // ========
  // Bus handshakes
  wire aw_take  = s_axi_awvalid & awready_reg;
  wire w_take   = s_axi_wvalid & wready_reg;
  wire ar_take  = s_axi_arvalid & arready_reg;
  wire do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire do_read  = ar_have_reg & ~rvalid_reg;
  wire aw_next  = (aw_have_reg | aw_take) & ~do_write;
  wire w_next   = (w_have_reg | w_take) & ~do_write;
  wire ar_next  = (ar_have_reg | ar_take) & ~do_read;

  // ========
  // Address decode
  wire [5:0] wa = aw_addr_reg[AXI_ADDR_W-1:2];
  wire [5:0] ra = ar_addr_reg[AXI_ADDR_W-1:2];

  wire wr_mask  = do_write & (wa == OFF_IRQ_MASK[7:2]);
  wire wr_sdat  = do_write & (wa == OFF_SINK_DATA[7:2]);
  wire wr_sien  = do_write & (wa == OFF_SINK_IEN[7:2]);
  wire wr_spol  = do_write & (wa == OFF_SINK_POL[7:2]);
  wire wr_slev  = do_write & (wa == OFF_SINK_LEVEL[7:2]);
  wire wr_gmask = do_write & (wa == OFF_GPIO_MASK[7:2]);
  wire wr_gpol  = do_write & (wa == OFF_GPIO_POL[7:2]);
  wire wr_ok    = wr_mask | wr_sdat | wr_sien | wr_spol | wr_slev | wr_gmask | wr_gpol;

  wire rd_stat  = do_read & (ra == OFF_IRQ_STATUS[7:2]);
  wire rd_tlo   = do_read & (ra == OFF_TIMER_LO[7:2]);

  // Byte-lane merge so that narrow writes leave untouched lanes alone.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire [31:0] m_mask  = merge({24'h0, mask_reg}, w_data_reg, w_strb_reg);
  wire [31:0] m_sdat  = merge({24'h0, drive_reg.pullup_en}, w_data_reg, w_strb_reg);
  wire [31:0] m_sien  = merge({24'h0, sink_ien_reg}, w_data_reg, w_strb_reg);
  wire [31:0] m_spol  = merge({24'h0, sink_pol_reg}, w_data_reg, w_strb_reg);
  wire [31:0] m_slev  = merge(drive_reg.level, w_data_reg, w_strb_reg);
  wire [31:0] m_gmask = merge(32'(gpio_mask_reg), w_data_reg, w_strb_reg);
  wire [31:0] m_gpol  = merge(32'(gpio_pol_reg), w_data_reg, w_strb_reg);

  // ========
  // Timer
  logic [TIMER_W-1:0] t_count;
  logic [3:0]         t_hold;
  logic               ev128;
  logic               ev1024;

  tisp_timer #(
    .DIV (DIV)
  ) u_timer (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .ce       (ce),
    .latch_hi (rd_tlo),
    .count    (t_count),
    .hold_hi  (t_hold),
    .ev128    (ev128),
    .ev1024   (ev1024)
  );

  // ========
  // Pin inputs
  logic [SINK_N-1:0] sink_state;
  logic [SINK_N-1:0] sink_evt;
  logic [GW-1:0]     gpio_state;
  logic [GW-1:0]     gpio_evt;
  logic [GW-1:0]     gpio_rise;

  for (genvar p = 0; p < GPIO_PORTS; p++) begin : g_gpol
    assign gpio_rise[p*GPIO_PORT_W +: GPIO_PORT_W] = {GPIO_PORT_W{gpio_pol_reg[p]}}; // RULE10
  end

  tisp_edge_det #(
    .W (SINK_N)
  ) u_sink_edge (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .pin     (sink_pin_in),
    .rise    (sink_pol_reg), // RULE9
    .state   (sink_state),
    .evt     (sink_evt)
  );

  tisp_edge_det #(
    .W (GW)
  ) u_gpio_edge (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .pin     (gpio_pin_in),
    .rise    (gpio_rise),
    .state   (gpio_state),
    .evt     (gpio_evt)
  );

  // ========
  // Interrupt events
  logic [N_SRC-1:0] ev;

  assign ev[SRC_BUS_RESET]            = usb_bus_reset_evt; // RULE2
  assign ev[SRC_T128]                 = ev128; // RULE3
  assign ev[SRC_T1024]                = ev1024; // RULE3
  assign ev[SRC_EP0 +: N_EP]          = usb_ep_done; // RULE4
  assign ev[SRC_SINK]                 = |(sink_evt & sink_ien_reg); // RULE6 RULE7
  assign ev[SRC_GPIO]                 = |(gpio_evt & gpio_mask_reg); // RULE5 RULE8

  // An event in the clearing cycle is ORed in last, so it survives the clear.
  wire [N_SRC-1:0] clr_rd  = rd_stat ? {N_SRC{1'b1}} : '0;
  wire [N_SRC-1:0] clr_ack = irq_ack ? (8'h01 << irq_ack_vector) : '0;
  wire [N_SRC-1:0] stat_nx = (status_reg & ~(clr_rd | clr_ack)) | ev; // RULE19
  wire [N_SRC-1:0] live_nx = stat_nx & (wr_mask ? m_mask[7:0] : mask_reg); // RULE1

  // Lowest source index has the highest priority.
  function automatic tisp_vec_t pick(input logic [N_SRC-1:0] p);
    tisp_vec_t v;
    v = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        v.valid  = 1'b1;
        v.vector = 3'(i);
      end
    end
    return v;
  endfunction : pick

  // ========
  // Read data
  wire [31:0] rd_word =
    (ra == OFF_IRQ_STATUS[7:2]) ? {24'h0, status_reg} :
    (ra == OFF_IRQ_MASK[7:2])   ? {24'h0, mask_reg} :
    (ra == OFF_TIMER_LO[7:2])   ? {24'h0, t_count[LO_W-1:0]} :
    (ra == OFF_TIMER_HI[7:2])   ? {28'h0, t_hold} : // RULE14
    (ra == OFF_SINK_DATA[7:2])  ? {16'h0, sink_state, drive_reg.pullup_en} :
    (ra == OFF_SINK_IEN[7:2])   ? {24'h0, sink_ien_reg} :
    (ra == OFF_SINK_POL[7:2])   ? {24'h0, sink_pol_reg} :
    (ra == OFF_SINK_LEVEL[7:2]) ? drive_reg.level :
    (ra == OFF_GPIO_MASK[7:2])  ? 32'(gpio_mask_reg) :
    (ra == OFF_GPIO_POL[7:2])   ? 32'(gpio_pol_reg) :
    (ra == OFF_VECTOR[7:2])     ? {28'h0, vec_reg} :
    32'h0000_0000;

  wire rd_ok = (ra <= OFF_VECTOR[7:2]);

  // ========
  // Bus channel registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      ar_have_reg <= 1'b0;
    end else if (ce) begin
      awready_reg <= ~aw_next;
      wready_reg  <= ~w_next;
      arready_reg <= ~ar_next;
      aw_have_reg <= aw_next;
      w_have_reg  <= w_next;
      ar_have_reg <= ar_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      ar_addr_reg <= '0;
    end else if (ce) begin
      aw_addr_reg <= aw_take ? s_axi_awaddr : aw_addr_reg;
      w_data_reg  <= w_take ? s_axi_wdata : w_data_reg;
      w_strb_reg  <= w_take ? s_axi_wstrb : w_strb_reg;
      ar_addr_reg <= ar_take ? s_axi_araddr : ar_addr_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (ce) begin
      bvalid_reg <= do_write | (bvalid_reg & ~s_axi_bready);
      bresp_reg  <= do_write ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_reg;
      rvalid_reg <= do_read | (rvalid_reg & ~s_axi_rready);
      rresp_reg  <= do_read ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rresp_reg;
      rdata_reg  <= do_read ? rd_word : rdata_reg; // RULE12
    end
  end

  // ========
  // Interrupt controller
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      status_reg <= '0;
      mask_reg   <= IRQ_MASK_RST;
      irq_reg    <= 1'b0;
      vec_reg    <= '0;
    end else if (ce) begin
      status_reg <= stat_nx; // RULE19
      mask_reg   <= wr_mask ? m_mask[7:0] : mask_reg; // RULE1
      irq_reg    <= |live_nx; // RULE19
      vec_reg    <= pick(live_nx);
    end
  end

  // ========
  // Sink port and GPIO configuration
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      drive_reg.pullup_en <= SINK_DATA_RST;
      drive_reg.sink_en   <= ~SINK_DATA_RST;
      drive_reg.level     <= SINK_LEVEL_RST;
      sink_ien_reg        <= SINK_IEN_RST;
      sink_pol_reg        <= SINK_POL_RST;
    end else if (ce) begin
      // Reset leaves every pin pulled up, so the port starts out usable as input.
      drive_reg.pullup_en <= wr_sdat ? m_sdat[7:0] : drive_reg.pullup_en; // RULE15 RULE18
      drive_reg.sink_en   <= wr_sdat ? ~m_sdat[7:0] : drive_reg.sink_en; // RULE16
      drive_reg.level     <= wr_slev ? m_slev : drive_reg.level; // RULE17
      sink_ien_reg        <= wr_sien ? m_sien[7:0] : sink_ien_reg; // RULE7
      sink_pol_reg        <= wr_spol ? m_spol[7:0] : sink_pol_reg; // RULE9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gpio_mask_reg <= '0;
      gpio_pol_reg  <= '0;
    end else if (ce) begin
      gpio_mask_reg <= wr_gmask ? m_gmask[GW-1:0] : gpio_mask_reg; // RULE8
      gpio_pol_reg  <= wr_gpol ? m_gpol[GPIO_PORTS-1:0] : gpio_pol_reg; // RULE10
    end
  end

  // ========
  // Outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = irq_reg;
  assign irq_vector    = vec_reg;
  assign sink_drive    = drive_reg;

endmodule : tisp_unit

/* File: tisp_pkg.sv */
// Shared constants, register map and carrier types of the timer, interrupt and sink port unit.
package tisp_pkg;

  // ========
  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_DIV       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 12;
  localparam int T128_BIT       = 7;
  localparam int T1024_BIT      = 10;
  localparam int LO_W           = 8;

  // ========
  // Interrupt sources
  localparam int N_SRC = 8;
  localparam int SRC_BUS_RESET = 0;
  localparam int SRC_T128      = 1;
  localparam int SRC_T1024     = 2;
  localparam int SRC_EP0       = 3;
  localparam int N_EP          = 3;
  localparam int SRC_SINK      = 6;
  localparam int SRC_GPIO      = 7;

  // ========
  // Register map
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h04;
  localparam logic [7:0] OFF_TIMER_LO   = 8'h08;
  localparam logic [7:0] OFF_TIMER_HI   = 8'h0c;
  localparam logic [7:0] OFF_SINK_DATA  = 8'h10;
  localparam logic [7:0] OFF_SINK_IEN   = 8'h14;
  localparam logic [7:0] OFF_SINK_POL   = 8'h18;
  localparam logic [7:0] OFF_SINK_LEVEL = 8'h1c;
  localparam logic [7:0] OFF_GPIO_MASK  = 8'h20;
  localparam logic [7:0] OFF_GPIO_POL   = 8'h24;
  localparam logic [7:0] OFF_VECTOR     = 8'h28;

  localparam int SINK_N       = 8;
  localparam int SINK_LEVEL_W = 4;
  localparam int GPIO_PORT_W  = 8;
  localparam int PIN_STATE_LSB = 8;

  localparam logic [7:0]  IRQ_MASK_RST   = 8'h00;
  localparam logic [7:0]  SINK_DATA_RST  = 8'hff;
  localparam logic [7:0]  SINK_IEN_RST   = 8'h00;
  localparam logic [7:0]  SINK_POL_RST   = 8'h00;
  localparam logic [31:0] SINK_LEVEL_RST = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ========
  // Carriers
  typedef struct packed {
    logic [31:0] level;
    logic [7:0]  pullup_en;
    logic [7:0]  sink_en;
  } tisp_sink_drive_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] vector;
  } tisp_vec_t;

endpackage : tisp_pkg

/* File: tisp_timer.sv */
// Free running microsecond timer with high nibble holding register.
module tisp_timer
  import tisp_pkg::*;
#(
  parameter int DIV = TICK_DIV
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  input  wire logic               latch_hi,
  output logic      [TIMER_W-1:0] count,
  output logic      [3:0]         hold_hi,
  output logic                    ev128,
  output logic                    ev1024
);

  if (DIV < 1) begin : g_chk
    $error("tisp_timer: DIV must be at least one");
  end

  localparam int DW = $clog2(DIV + 1);

  logic [DW-1:0]      div_reg;
  logic [TIMER_W-1:0] cnt_reg;
  logic [3:0]         hold_reg;
  logic               e128_reg;
  logic               e1024_reg;
  wire                tick     = (div_reg == DW'(DIV - 1));
  wire [TIMER_W-1:0]  cnt_next = cnt_reg + 12'h001;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      div_reg   <= '0;
      cnt_reg   <= '0;
      hold_reg  <= '0;
      e128_reg  <= 1'b0;
      e1024_reg <= 1'b0;
    end else if (ce) begin
      div_reg   <= tick ? '0 : div_reg + DW'(1);
      cnt_reg   <= tick ? cnt_next : cnt_reg; // RULE12
      hold_reg  <= latch_hi ? cnt_reg[TIMER_W-1:LO_W] : hold_reg; // RULE13
      e128_reg  <= tick & ~cnt_reg[T128_BIT] & cnt_next[T128_BIT]; // RULE3
      e1024_reg <= tick & ~cnt_reg[T1024_BIT] & cnt_next[T1024_BIT]; // RULE3
    end
  end

  assign count   = cnt_reg;
  assign hold_hi = hold_reg;
  assign ev128   = e128_reg;
  assign ev1024  = e1024_reg;

endmodule : tisp_timer

/* File: tisp_edge_det.sv */
// Pin synchroniser with per-bit programmable transition detection.
module tisp_edge_det
  import tisp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  input  wire logic [W-1:0] rise,
  output logic      [W-1:0] state,
  output logic      [W-1:0] evt
);

  if (W < 1) begin : g_chk
    $error("tisp_edge_det: W must be at least one");
  end

  // ========
  // Per pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic st_reg;
    logic ev_reg;
    // A change counts only once two late stages agree, which rejects a metastable sample.
    wire  chg = (s2_reg == s3_reg) & (s3_reg != st_reg);
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
        s3_reg <= 1'b1;
        st_reg <= 1'b1;
        ev_reg <= 1'b0;
      end else if (ce) begin
        s1_reg <= pin[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        st_reg <= chg ? s3_reg : st_reg;
        ev_reg <= chg & (s3_reg == rise[i]); // RULE11
      end
    end
    assign state[i] = st_reg;
    assign evt[i]   = ev_reg;
  end

endmodule : tisp_edge_det

/* File: tisp_unit_props.sv */
// Concurrent checks on the ports of the timer, interrupt and sink port unit.
module tisp_unit_props
  import tisp_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             irq_ack,
  input wire logic             irq,
  input wire tisp_vec_t        irq_vector,
  input wire tisp_sink_drive_t sink_drive
);
  // ========
  // Properties
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  irq_vec_a: assert property (irq == irq_vector.valid)
    else $error("irq and vector valid disagree");
  sink_drive_a: assert property (sink_drive.pullup_en == ~sink_drive.sink_en)
    else $error("pull-up and sink on together");
  // A write commits at the edge that raises bvalid, whatever order address and data came in.
  drive_by_write_a: assert property ($changed(sink_drive) |-> $rose(s_axi_bvalid))
    else $error("sink drive changed without a write");
  // A status read or mask write drops irq with its answer; an ack drops it one edge later.
  irq_fall_a: assert property ($fell(irq) |-> $past(irq_ack) || $rose(s_axi_rvalid) || $rose(s_axi_bvalid))
    else $error("irq dropped with no cause");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  rd_busy_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("second read taken early");
endmodule : tisp_unit_props

bind tisp_unit tisp_unit_props i_tisp_unit_props (.*);

/* File: tisp_core_model.sv */
// Behavioural core that acknowledges the pending interrupt vector after a set lag.
module tisp_core_model
  import tisp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       en,
  input  wire logic [3:0] lag,
  input  wire logic       irq,
  input  wire tisp_vec_t  irq_vector,
  output logic            irq_ack = 1'b0,
  output logic      [2:0] irq_ack_vector = 3'h0
);
  // ========
  // Service
  // The irq_ack guard keeps even a lag of 0 from acknowledging the stale vector again before irq settles.
  logic [3:0] wait_reg;
  always_ff @(posedge ref_clk) begin
    irq_ack <= 1'b0;
    if (!rstn || !en || !irq) begin
      wait_reg <= 4'h0;
    end else if (wait_reg == lag && !irq_ack) begin
      irq_ack <= 1'b1;
      irq_ack_vector <= irq_vector.vector;
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : tisp_core_model

/* File: tisp_unit_bench.sv */
// Self-checking bench of the timer, interrupt and sink port unit.
module tisp_unit_bench
  import tisp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // Wiring
  logic             ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, core_en = 1'b0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, usb_bus_reset_evt = 1'b0;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, irq_ack;
  logic [7:0]       s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sink_pin_in = 8'hff;
  logic [31:0]      s_axi_wdata = 32'h0, gpio_pin_in = 32'hffffffff, s_axi_rdata, rd_data;
  logic [3:0]       s_axi_wstrb = 4'hf, core_lag = 4'h2;
  logic [2:0]       usb_ep_done = 3'h0, irq_ack_vector;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  tisp_vec_t        irq_vector;
  tisp_sink_drive_t sink_drive;
  int               miscompares = 0, compares = 0;

  always #25 ref_clk = ~ref_clk;

  tisp_unit #(.GPIO_PORTS(4), .DIV(2)) i_tisp_unit (.*);
  tisp_core_model i_tisp_core_model (.ref_clk, .rstn, .en(core_en), .lag(core_lag), .irq, .irq_vector,
    .irq_ack, .irq_ack_vector);

  // ========
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] expd);
    compares++;
    if (seen !== expd) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, expd, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(nm, rd_data & m, e);
  endtask : rd_chk

  task automatic wait_irq(input logic lvl, input int mx);
    for (int n = 0; n < mx && irq !== lvl; n++) @(posedge ref_clk);
    check("irq", 32'(irq), 32'(lvl));
  endtask : wait_irq

  task automatic vec(input int v);
    check("vector", 32'(irq_vector), 32'(8 + v));
  endtask : vec

  task automatic pulse(input logic bus_rst, input logic [2:0] ep);
    usb_bus_reset_evt <= bus_rst;
    usb_ep_done <= ep;
    tick(1);
    usb_bus_reset_evt <= 1'b0;
    usb_ep_done <= 3'h0;
    tick(3);
  endtask : pulse

  // ========
  // Scenarios
  task automatic t_regs();
    check("pullup", 32'(sink_drive.pullup_en), 32'(SINK_DATA_RST));
    rd_chk("mask", OFF_IRQ_MASK, 32'hff, 32'(IRQ_MASK_RST));
    rd_chk("ien", OFF_SINK_IEN, 32'hff, 32'(SINK_IEN_RST));
    rd_chk("pol", OFF_SINK_POL, 32'hff, 32'(SINK_POL_RST));
    rd(8'h2c, RESP_SLVERR);
    check("unmapped", rd_data, 32'h0);
    wr(OFF_IRQ_STATUS, 32'hff, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
  endtask : t_regs

  task automatic t_drive();
    wr(OFF_SINK_LEVEL, 32'hfedcba98);
    wr(OFF_SINK_DATA, 32'h5a);
    check("level", sink_drive.level, 32'hfedcba98);
    check("pullup", 32'(sink_drive.pullup_en), 32'h5a);
    check("sink", 32'(sink_drive.sink_en), 32'ha5);
    wr(OFF_SINK_DATA, 32'hff);
  endtask : t_drive

  task automatic t_events();
    wr(OFF_IRQ_MASK, 32'h39);
    rd(OFF_IRQ_STATUS);
    for (int i = 0; i < N_EP; i++) begin
      pulse(1'b0, 3'(1 << i));
      vec(SRC_EP0 + i);
      rd_chk("ep", OFF_IRQ_STATUS, 32'h39, 32'h08 << i);
    end
    pulse(1'b1, 3'h4);
    vec(SRC_BUS_RESET);
    rd_chk("both", OFF_IRQ_STATUS, 32'h39, 32'h21);
    wr(OFF_IRQ_MASK, 32'h0);
    pulse(1'b0, 3'h1);
    check("masked", 32'(irq), 32'h0);
    rd_chk("sticky", OFF_IRQ_STATUS, 32'h08, 32'h08);
  endtask : t_events

  task automatic t_timer();
    logic [11:0] t0, t1;
    rd(OFF_TIMER_LO);
    t0[7:0] = rd_data[7:0];
    rd(OFF_TIMER_HI);
    t0[11:8] = rd_data[3:0];
    tick(200);
    rd(OFF_TIMER_LO);
    t1[7:0] = rd_data[7:0];
    rd(OFF_TIMER_HI);
    t1[11:8] = rd_data[3:0];
    check("elapsed", 32'((t1 - t0) inside {[12'd100:12'd108]}), 32'h1);
    tick(600);
    rd_chk("hold", OFF_TIMER_HI, 32'hf, 32'(t1[11:8]));
    wr(OFF_IRQ_MASK, 32'h02);
    rd(OFF_IRQ_STATUS);
    wait_irq(1'b1, 600);
    vec(SRC_T128);
    rd(OFF_IRQ_STATUS);
    tick(300);
    rd_chk("no_fall", OFF_IRQ_STATUS, 32'h02, 32'h0);
    wr(OFF_IRQ_MASK, 32'h04);
    rd(OFF_IRQ_STATUS);
    wait_irq(1'b1, 4200);
    vec(SRC_T1024);
  endtask : t_timer

  task automatic t_pins();
    wr(OFF_SINK_IEN, 32'h03);
    wr(OFF_SINK_POL, 32'h01);
    wr(OFF_GPIO_MASK, 32'h100);
    wr(OFF_GPIO_POL, 32'h2);
    wr(OFF_IRQ_MASK, 32'hc0);
    sink_pin_in <= 8'hfa;
    gpio_pin_in <= 32'hfffffcff;
    tick(10);
    rd_chk("quiet", OFF_IRQ_STATUS, 32'hc0, 32'h0);
    sink_pin_in <= 8'hf8;
    wait_irq(1'b1, 20);
    vec(SRC_SINK);
    rd(OFF_IRQ_STATUS);
    sink_pin_in <= 8'hf9;
    gpio_pin_in <= 32'hfffffeff;
    tick(10);
    rd_chk("rise", OFF_IRQ_STATUS, 32'hc0, 32'h40);
    gpio_pin_in <= 32'hffffffff;
    wait_irq(1'b1, 20);
    vec(SRC_GPIO);
  endtask : t_pins

  task automatic t_ack();
    core_en <= 1'b1;
    wr(OFF_IRQ_MASK, 32'h01);
    for (int i = 0; i < 2; i++) begin
      core_lag <= i ? 4'h9 : 4'h2;
      pulse(1'b1, 3'h0);
      wait_irq(1'b0, 30);
      rd_chk("acked", OFF_IRQ_STATUS, 32'h01, 32'h0);
    end
  endtask : t_ack

  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    tick(2);
    rstn <= 1'b1;
    tick(1);
    t_regs();
    t_drive();
    t_events();
    t_timer();
    t_pins();
    t_ack();
    end_of_test();
  end

  // The timer scenarios need about 2000 cycles; anything far beyond is a hang.
  initial begin
    tick(20000);
    miscompares++;
    end_of_test();
  end
endmodule : tisp_unit_bench
